// *** rtl/ebc_regs.svh ***
// constants of the external bus cycle sequencer: register map, fields, resets, counts
// assumes inclusion by its bare name from any file that needs it
`ifndef EBC_REGS_SVH
`define EBC_REGS_SVH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define OFS_CTRL        12'h000
`define OFS_TIMING0     12'h004
`define OFS_TIMING1     12'h008
`define OFS_ADDR        12'h00C
`define OFS_WDATA       12'h010
`define OFS_CMD         12'h014
`define OFS_STATUS      12'h018
`define OFS_RDATA       12'h01C

// ************************************************************
// ctrl fields
// ************************************************************
`define CTRL_MUX_BIT    0
`define CTRL_RDYEN_BIT  1
`define CTRL_RDYPOL_BIT 2
`define CTRL_RDYASY_BIT 3
`define CTRL_CLKEN_BIT  4
`define CTRL_RESET      32'h0000_0000

// ************************************************************
// timing config fields (one word per region)
// ************************************************************
`define TC_AB_LSB       0
`define TC_ABX_LSB      1
`define TC_C_LSB        3
`define TC_D_BIT        5
`define TC_E_LSB        6
`define TC_F_LSB        11
`define TC_RESET        32'h0000_0000

// ************************************************************
// command and status fields
// ************************************************************
`define CMD_WRITE_BIT   0
`define CMD_REGION_BIT  1
`define CMD_BHE_BIT     2
`define STAT_BUSY_BIT   0
`define STAT_DONE_BIT   1

// ************************************************************
// widths and counts
// ************************************************************
`define ADDR_W          24
`define DATA_W          16
`define WIN_LSB         16

`endif

// *** rtl/ebc_pkg.sv ***
// types shared by the external bus cycle sequencer
// assumes nothing beyond a SystemVerilog compiler
package ebc_pkg;
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ADDR,
        PH_CMD,
        PH_WDS,
        PH_ACC,
        PH_RDY,
        PH_HOLD
    } phase_t;
endpackage

// *** rtl/link_side.sv ***
// link-side logic on link_clk: ready sampling and read data capture
// assumes strobes from the system side reach it as levels through two flops
`timescale 1ns/1ps
`default_nettype none
module link_side
    import ebc_pkg::*;
(
    input  wire logic         link_clk,
    input  wire logic         link_resetn,
    input  wire logic         ready_pin,
    input  wire logic         ready_pol,
    input  wire logic         ready_async,
    input  wire logic [15:0]  rdata_pin,
    input  wire logic         capture_lvl,
    output logic              ready_sync,
    output logic [15:0]       rdata_held
);
    // ************************************************************
    // ready and capture stages
    // ************************************************************
    logic        rdy_a_ff;
    logic        rdy_b_ff;
    logic        cap_a_ff;
    logic        cap_b_ff;
    logic        cap_c_ff;
    logic        nxt_rdy_a;
    logic        nxt_rdy_b;
    logic        nxt_ready;
    logic [15:0] nxt_rdata;
    logic        rdy_lvl;

    always_comb begin
        rdy_lvl   = ready_pin ^ ~ready_pol;                  // see (RQ13)
        nxt_rdy_a = rdy_lvl;
        nxt_rdy_b = rdy_a_ff;
        // async mode costs two extra synchroniser stages (rdy_a_ff, rdy_b_ff), hence extra wait states
        nxt_ready = ready_async ? rdy_b_ff : rdy_lvl;        // see (RQ14)
        // capture on the rising edge of the capture level (strobe end)
        nxt_rdata = (cap_b_ff & ~cap_c_ff) ? rdata_pin : rdata_held; // see (RQ8)
    end

    always_ff @(posedge link_clk) begin
        if (!link_resetn) begin
            rdy_a_ff   <= 1'b0;
            rdy_b_ff   <= 1'b0;
            ready_sync <= 1'b0;
            cap_a_ff   <= 1'b0;
            cap_b_ff   <= 1'b0;
            cap_c_ff   <= 1'b0;
            rdata_held <= 16'h0000;
        end else begin
            rdy_a_ff   <= nxt_rdy_a;
            rdy_b_ff   <= nxt_rdy_b;
            ready_sync <= nxt_ready;
            cap_a_ff   <= capture_lvl;
            cap_b_ff   <= cap_a_ff;
            cap_c_ff   <= cap_b_ff;
            rdata_held <= nxt_rdata;
        end
    end
endmodule
`default_nettype wire

// *** rtl/ebc_top.sv ***
// external bus cycle sequencer with AHB-Lite register slave
// assumes a single AHB-Lite master; link logic runs on link_clk, synchronous reset
//
// Behaviour
// (RQ1) five phases run in fixed order
// (RQ2) phase lengths from selected region config
// (RQ3) ready input may stretch access phase
// (RQ4) address setup 1-2 units plus window extra
// (RQ5) command 0-3 units, access 1-32 units
// (RQ6) write setup or turnaround 0-1 unit
// (RQ7) hold phase 0-3 units
// (RQ8) read data caught at strobe end edge
// (RQ9) address change never disturbs captured data
// (RQ10) external keeps read data until strobe rises
// (RQ11) demux mode drives separate data lines
// (RQ12) reference clock output from system clock
// (RQ13) ready polarity selectable by software
// (RQ14) async ready adds synchroniser stage
// (RQ15) wait while not ready, end when ready
// (RQ16) sync ready driven on reference clock
// (RQ17) zero-length phases are skipped
// (RQ18) mux mode drives address and pulses latch
`timescale 1ns/1ps
`default_nettype none
`include "ebc_regs.svh"
module ebc_top
    import ebc_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         clk_en,
    input  wire logic         link_clk,
    input  wire logic         link_resetn,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic [31:0]       hrdata,
    output logic              hreadyout,
    output logic              hresp,
    output logic              bus_reference_clock,
    output logic              clock_driver_en,
    output logic [23:0]       dedicated_addr_lines,
    output logic [15:0]       shared_addr_data_o,
    output logic              shared_addr_data_oe,
    input  wire logic [15:0]  shared_addr_data_i,
    output logic [15:0]       dedicated_data_o,
    output logic              dedicated_data_oe,
    input  wire logic [15:0]  dedicated_data_i,
    output logic              addr_latch,
    output logic              read_n,
    output logic              write_n,
    output logic              high_byte_enable_n,
    output logic [1:0]        chip_select_n,
    input  wire logic         ready_pin
);
    // ************************************************************
    // bus slave
    // ************************************************************
    logic        ap_wr_ff;
    logic        ap_rd_ff;
    logic [11:0] ap_ofs_ff;
    logic        nxt_ap_wr;
    logic        nxt_ap_rd;
    logic [11:0] nxt_ap_ofs;
    logic [31:0] ctrl_ff;
    logic [31:0] tc0_ff;
    logic [31:0] tc1_ff;
    logic [23:0] addr_ff;
    logic [15:0] wdata_ff;
    logic [2:0]  cmd_ff;
    logic        done_ff;
    logic        go_ff;
    logic [31:0] nxt_ctrl;
    logic [31:0] nxt_tc0;
    logic [31:0] nxt_tc1;
    logic [23:0] nxt_addr;
    logic [15:0] nxt_wdata;
    logic [2:0]  nxt_cmd;
    logic        nxt_done;
    logic        nxt_go;
    logic [31:0] nxt_hrdata;
    logic        busy;
    logic        cyc_end;
    logic [15:0] rdata_sys;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_comb begin
        nxt_ap_wr  = hsel & hready & htrans[1] & hwrite;
        nxt_ap_rd  = hsel & hready & htrans[1] & ~hwrite;
        nxt_ap_ofs = haddr[11:0];
        nxt_ctrl   = ctrl_ff;
        nxt_tc0    = tc0_ff;
        nxt_tc1    = tc1_ff;
        nxt_addr   = addr_ff;
        nxt_wdata  = wdata_ff;
        nxt_cmd    = cmd_ff;
        nxt_go     = 1'b0;
        nxt_done   = done_ff;
        nxt_hrdata = hrdata;
        if (ap_wr_ff && !busy) begin
            unique case (ap_ofs_ff)
                `OFS_CTRL:    nxt_ctrl  = {27'h0000000, hwdata[4:0]};
                `OFS_TIMING0: nxt_tc0   = {19'h00000, hwdata[12:0]};
                `OFS_TIMING1: nxt_tc1   = {19'h00000, hwdata[12:0]};
                `OFS_ADDR:    nxt_addr  = hwdata[23:0];
                `OFS_WDATA:   nxt_wdata = hwdata[15:0];
                `OFS_CMD: begin
                    nxt_cmd  = hwdata[2:0];
                    nxt_go   = 1'b1;
                    nxt_done = 1'b0;
                end
                default: ;
            endcase
        end
        // completion wins over a software clear in the same cycle
        if (cyc_end) begin
            nxt_done = 1'b1;
        end
        // decoded in the address phase so the word stands in the data phase (zero wait);
        // limitation: a read issued in the data phase of a write to that word sees the old one
        if (nxt_ap_rd) begin
            unique case (haddr[11:0])
                `OFS_CTRL:    nxt_hrdata = ctrl_ff;
                `OFS_TIMING0: nxt_hrdata = tc0_ff;
                `OFS_TIMING1: nxt_hrdata = tc1_ff;
                `OFS_ADDR:    nxt_hrdata = {8'h00, addr_ff};
                `OFS_WDATA:   nxt_hrdata = {16'h0000, wdata_ff};
                `OFS_CMD:     nxt_hrdata = {29'h00000000, cmd_ff};
                `OFS_STATUS:  nxt_hrdata = {30'h00000000, done_ff, busy};
                `OFS_RDATA:   nxt_hrdata = {16'h0000, rdata_sys};
                default:      nxt_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // phase sequencer
    // ************************************************************
    phase_t      ph_ff;
    phase_t      nxt_ph;
    logic [5:0]  cnt_ff;
    logic [5:0]  nxt_cnt;
    logic [7:0]  win_ff;
    logic [7:0]  nxt_win;
    logic [31:0] tc;
    logic [2:0]  len_ab;
    logic [1:0]  len_c;
    logic        len_d;
    logic [5:0]  len_e;
    logic [1:0]  len_f;
    logic        mux;
    logic        rdy_en;
    logic        ready_sync;
    logic        rdy_s1_ff;
    logic        rdy_s2_ff;
    logic        cap_lvl_ff;
    logic        nxt_cap_lvl;
    logic [15:0] rd_cap_ff;
    logic [15:0] nxt_rd_cap;
    logic [15:0] rdata_pin;

    always_comb begin
        tc     = cmd_ff[`CMD_REGION_BIT] ? tc1_ff : tc0_ff;   // see (RQ2)
        mux    = ctrl_ff[`CTRL_MUX_BIT];
        rdy_en = ctrl_ff[`CTRL_RDYEN_BIT];
        // base 1-2 units, extra 0-3 only on window change, at most five
        len_ab = 3'(tc[`TC_AB_LSB] + 1'b1)
               + ((addr_ff[23:16] != win_ff) ? 3'(tc[`TC_ABX_LSB +: 2]) : 3'h0); // see (RQ4)
        len_c  = tc[`TC_C_LSB +: 2];                            // see (RQ5)
        len_d  = tc[`TC_D_BIT];                                 // see (RQ6)
        len_e  = 6'(tc[`TC_E_LSB +: 5]) + 6'h01;                // see (RQ5)
        len_f  = tc[`TC_F_LSB +: 2];                            // see (RQ7)
    end

    always_comb begin
        nxt_ph      = ph_ff;
        nxt_cnt     = cnt_ff - 6'h01;
        nxt_win     = win_ff;
        nxt_cap_lvl = cap_lvl_ff;
        cyc_end     = 1'b0;
        nxt_rd_cap  = rd_cap_ff;
        unique case (ph_ff)
            PH_IDLE: begin
                nxt_cnt = cnt_ff;
                if (go_ff) begin
                    nxt_ph      = PH_ADDR;
                    nxt_cnt     = {3'h0, len_ab};
                    nxt_cap_lvl = 1'b0;
                end
            end
            // zero lengths fall straight through to the next phase
            PH_ADDR: if (cnt_ff == 6'h01) begin                 // see (RQ1)
                nxt_win = addr_ff[23:16];
                if (len_c != 2'h0) begin nxt_ph = PH_CMD; nxt_cnt = {4'h0, len_c}; end
                else if (len_d) begin nxt_ph = PH_WDS; nxt_cnt = 6'h01; end
                else begin nxt_ph = PH_ACC; nxt_cnt = len_e; end // see (RQ17)
            end
            PH_CMD: if (cnt_ff == 6'h01) begin
                if (len_d) begin nxt_ph = PH_WDS; nxt_cnt = 6'h01; end
                else begin nxt_ph = PH_ACC; nxt_cnt = len_e; end // see (RQ17)
            end
            PH_WDS: begin
                nxt_ph  = PH_ACC;
                nxt_cnt = len_e;
            end
            PH_ACC: if (cnt_ff == 6'h01) begin
                nxt_ph = (rdy_en && !rdy_s2_ff) ? PH_RDY : PH_HOLD; // see (RQ3)
                nxt_cnt = {4'h0, len_f};
                nxt_cap_lvl = !(rdy_en && !rdy_s2_ff);           // see (RQ8)
                if (!(rdy_en && !rdy_s2_ff) && len_f == 2'h0) begin
                    nxt_ph  = PH_IDLE;
                    cyc_end = 1'b1;
                end
            end
            PH_RDY: begin
                nxt_cnt = {4'h0, len_f};
                if (rdy_s2_ff) begin                             // see (RQ15)
                    nxt_cap_lvl = 1'b1;
                    nxt_ph      = (len_f == 2'h0) ? PH_IDLE : PH_HOLD;
                    cyc_end     = (len_f == 2'h0);
                end
            end
            PH_HOLD: if (cnt_ff == 6'h01) begin
                nxt_ph  = PH_IDLE;
                cyc_end = 1'b1;
            end
        endcase
        // read data is timed on the reference clock, i.e. clk: caught at the strobe-end edge
        if (nxt_cap_lvl && !cap_lvl_ff && !cmd_ff[`CMD_WRITE_BIT]) begin
            nxt_rd_cap = rdata_pin;                              // see (RQ8)
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ap_wr_ff   <= 1'b0;
            ap_rd_ff   <= 1'b0;
            ap_ofs_ff  <= 12'h000;
            ctrl_ff    <= `CTRL_RESET;
            tc0_ff     <= `TC_RESET;
            tc1_ff     <= `TC_RESET;
            addr_ff    <= 24'h000000;
            wdata_ff   <= 16'h0000;
            cmd_ff     <= 3'h0;
            go_ff      <= 1'b0;
            done_ff    <= 1'b0;
            hrdata     <= 32'h0000_0000;
            ph_ff      <= PH_IDLE;
            cnt_ff     <= 6'h00;
            win_ff     <= 8'h00;
            cap_lvl_ff <= 1'b0;
            rdy_s1_ff  <= 1'b0;
            rdy_s2_ff  <= 1'b0;
            rd_cap_ff  <= 16'h0000;
        end else if (clk_en) begin
            ap_wr_ff   <= nxt_ap_wr;
            ap_rd_ff   <= nxt_ap_rd;
            ap_ofs_ff  <= nxt_ap_ofs;
            ctrl_ff    <= nxt_ctrl;
            tc0_ff     <= nxt_tc0;
            tc1_ff     <= nxt_tc1;
            addr_ff    <= nxt_addr;
            wdata_ff   <= nxt_wdata;
            cmd_ff     <= nxt_cmd;
            go_ff      <= nxt_go;
            done_ff    <= nxt_done;
            hrdata     <= nxt_hrdata;
            ph_ff      <= nxt_ph;
            cnt_ff     <= nxt_cnt;
            win_ff     <= nxt_win;
            cap_lvl_ff <= nxt_cap_lvl;
            rdy_s1_ff  <= ready_sync;
            rdy_s2_ff  <= rdy_s1_ff;
            rd_cap_ff  <= nxt_rd_cap;
        end
    end

    assign busy      = (ph_ff != PH_IDLE) | go_ff;
    assign rdata_sys = rd_cap_ff;

    // ************************************************************
    // pins
    // ************************************************************
    logic in_cyc;
    logic is_wr;

    always_comb begin
        in_cyc    = (ph_ff != PH_IDLE);
        is_wr     = cmd_ff[`CMD_WRITE_BIT];
        rdata_pin = mux ? shared_addr_data_i : dedicated_data_i;
    end

    // reference clock is the system clock gated only by the driver enable
    assign bus_reference_clock  = clk & ctrl_ff[`CTRL_CLKEN_BIT];  // see (RQ12)
    assign clock_driver_en      = ctrl_ff[`CTRL_CLKEN_BIT];        // see (RQ12)
    // address holds through the whole cycle since register writes are ignored while busy; data is caught at the strobe-end edge itself
    assign dedicated_addr_lines = addr_ff;                          // see (RQ9)
    assign shared_addr_data_o   = (ph_ff == PH_ADDR) ? addr_ff[15:0] : wdata_ff; // see (RQ18)
    assign shared_addr_data_oe  = mux & ((ph_ff == PH_ADDR) | (is_wr & in_cyc &
                                  (ph_ff != PH_CMD) & (ph_ff != PH_WDS)));
    assign dedicated_data_o     = wdata_ff;
    assign dedicated_data_oe    = ~mux & is_wr & in_cyc & (ph_ff != PH_ADDR); // see (RQ11)
    assign addr_latch           = mux & (ph_ff == PH_ADDR);        // see (RQ18)
    assign read_n  = ~(~is_wr & ((ph_ff == PH_ACC) | (ph_ff == PH_RDY)));  // see (RQ10)
    assign write_n = ~(is_wr & ((ph_ff == PH_ACC) | (ph_ff == PH_RDY)));
    assign high_byte_enable_n   = ~(in_cyc & cmd_ff[`CMD_BHE_BIT]);
    assign chip_select_n        = ~({2{in_cyc}} & {cmd_ff[`CMD_REGION_BIT],
                                   ~cmd_ff[`CMD_REGION_BIT]});

    link_side u_link (
        .link_clk    (link_clk),
        .link_resetn (link_resetn),
        .ready_pin   (ready_pin),
        .ready_pol   (ctrl_ff[`CTRL_RDYPOL_BIT]),
        .ready_async (ctrl_ff[`CTRL_RDYASY_BIT]),
        .rdata_pin   (rdata_pin),
        .capture_lvl (cap_lvl_ff),
        .ready_sync  (ready_sync),
        .rdata_held  ()
    );
endmodule
`default_nettype wire

// *** tb/ebc_mem_model.sv ***
// partner: external memory or peripheral on the parallel bus
// assumes ready and read data are timed on the bus reference clock
`timescale 1ns/1ps
`default_nettype none
module ebc_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        read_n,
    input  wire logic        write_n,
    input  wire logic [15:0] rd_value,
    input  wire logic [3:0]  ready_wait,
    input  wire logic        ready_pol,
    output logic [15:0]      dq,
    output logic             ready_pin
);
    // ********
    // strobe tracking
    // ********
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic       hold_ff = 1'b0;
    logic       idle;
    assign idle = read_n && write_n;
    always_comb nxt_cnt = idle ? 4'h0 : cnt_ff + {3'h0, cnt_ff != 4'hF};
    always_ff @(posedge ref_clk) begin
        cnt_ff  <= nxt_cnt;
        hold_ff <= !read_n;
    end
    // kept one clock past the strobe, then inverted so stale data cannot pass
    assign dq = (!read_n || hold_ff) ? rd_value : ~rd_value;
    // ready only inside a strobe and dropped with it
    assign ready_pin = ((cnt_ff >= ready_wait) && !idle) ~^ ready_pol;
endmodule
`default_nettype wire

// *** tb/ebc_top_chk.sv ***
// checker: shape of bus cycles at the sequencer pins
// assumes binding into ebc_top, one clk domain, sync active-low reset
`timescale 1ns/1ps
`default_nettype none
module ebc_chk (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       read_n,
    input wire logic       write_n,
    input wire logic       addr_latch,
    input wire logic       shared_addr_data_oe,
    input wire logic       dedicated_data_oe,
    input wire logic       high_byte_enable_n,
    input wire logic [1:0] chip_select_n
);
    // ********
    // properties
    // ********
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence strobe_end;
        $rose(read_n) || $rose(write_n);
    endsequence
    sequence quiet_gap;
        (read_n && write_n)[*3];
    endsequence
    strobe_excl_a: assert property (read_n || write_n)
        else $error("both strobes low");
    strobe_cs_a: assert property (!(read_n && write_n) |-> chip_select_n != 2'b11)
        else $error("strobe without chip select");
    latch_phase_a: assert property (addr_latch |-> read_n && write_n && shared_addr_data_oe)
        else $error("latch outside address phase");
    read_float_a: assert property (!read_n |-> !shared_addr_data_oe && !dedicated_data_oe)
        else $error("data bus driven in read");
    write_drive_a: assert property (!write_n |-> shared_addr_data_oe || dedicated_data_oe)
        else $error("write data not driven");
    cs_steady_a: assert property ((!read_n ##1 !read_n) |-> $stable(chip_select_n))
        else $error("chip select moved in read");
    latch_len_a: assert property ($rose(addr_latch) |-> ##[1:5] !addr_latch)
        else $error("address phase too long");
    cycle_gap_a: assert property (strobe_end |-> quiet_gap)
        else $error("strobe again too soon");
    bhe_cycle_a: assert property (!high_byte_enable_n |-> chip_select_n != 2'b11)
        else $error("byte enable outside cycle");
endmodule
bind ebc_top ebc_chk i_chk (.clk, .resetn, .read_n, .write_n, .addr_latch, .shared_addr_data_oe,
    .dedicated_data_oe, .high_byte_enable_n, .chip_select_n);
`default_nettype wire

// *** tb/test_external_bus_cycle_sequencer.sv ***
// testbench of the external bus cycle sequencer
// assumes AHB-Lite register map of ebc_regs.svh and the memory model
`timescale 1ns/1ps
`default_nettype none
`include "ebc_regs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_external_bus_cycle_sequencer;
    // ********
    // signals
    // ********
    logic clk = 1'b0, link_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, clk_en = 1'b1;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0]  htrans = 2'b00, chip_select_n, cs;
    logic [2:0]  hsize = 3'b010;
    logic        hreadyout, hresp, bus_reference_clock, clock_driver_en, addr_latch;
    logic        read_n, write_n, high_byte_enable_n, shared_addr_data_oe, dedicated_data_oe;
    logic        ready_pin, ready_pol = 1'b1;
    logic [23:0] dedicated_addr_lines;
    logic [15:0] shared_addr_data_o, dedicated_data_o, mdl_dq, lat, wd, rd_value = 16'h0000;
    logic [3:0]  ready_wait = 4'h0;
    int          err_total = 0, n_tests = 0, cyc = 0;
    wire  [15:0] shared_addr_data_i = shared_addr_data_oe ? shared_addr_data_o : mdl_dq;
    wire  [15:0] dedicated_data_i = dedicated_data_oe ? dedicated_data_o : mdl_dq;
    initial forever #2.5 clk = ~clk;
    initial #1.3 forever #3 link_clk = ~link_clk;
    ebc_top i_dut (.clk, .resetn, .clk_en, .link_clk, .link_resetn(resetn), .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .bus_reference_clock, .clock_driver_en, .dedicated_addr_lines,
        .shared_addr_data_o, .shared_addr_data_oe, .shared_addr_data_i, .dedicated_data_o,
        .dedicated_data_oe, .dedicated_data_i, .addr_latch, .read_n, .write_n,
        .high_byte_enable_n, .chip_select_n, .ready_pin);
    ebc_mem_model i_mem (.ref_clk(bus_reference_clock), .read_n, .write_n, .rd_value,
        .ready_wait, .ready_pol, .dq(mdl_dq), .ready_pin);
    // ********
    // bus tasks
    // ********
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {20'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        `CHK(x, e)
    endtask
    function automatic logic [31:0] tc(input int ab, abx, c, d, e, f);
        return 32'(((ab - 1) << `TC_AB_LSB) | (abx << `TC_ABX_LSB) | (c << `TC_C_LSB)
            | (d << `TC_D_BIT) | ((e - 1) << `TC_E_LSB) | (f << `TC_F_LSB));
    endfunction
    // starts one cycle and counts its phases from the pins
    task automatic bus_cycle(input logic [31:0] cmd, input int pre_x, acc_x, post_x,
                             input logic at_least);
        logic [31:0] x;
        int pre, acc, post;
        pre = 0; acc = 0; post = 0;
        wr(`OFS_CMD, cmd);
        while (chip_select_n === 2'b11) @(posedge clk);
        while (read_n && write_n) begin
            if (addr_latch) lat = shared_addr_data_o;
            pre++; @(posedge clk);
        end
        while (!read_n || !write_n) begin
            cs = chip_select_n; wd = dedicated_data_o; acc++; @(posedge clk);
        end
        while (chip_select_n !== 2'b11) begin post++; @(posedge clk); end
        `CHK(pre, pre_x)
        if (at_least) `CHK(acc >= acc_x, 1'b1) else `CHK(acc, acc_x)
        `CHK(post, post_x)
        do ahb(1'b0, `OFS_STATUS, 32'h0, x); while (x[`STAT_DONE_BIT] !== 1'b1);
        repeat (12) @(posedge clk);
    endtask
    // ********
    // scenarios
    // ********
    task automatic t_regs;
        rd_chk(`OFS_CTRL, 32'h0);
        rd_chk(`OFS_TIMING0, 32'h0);
        rd_chk(`OFS_STATUS, 32'h0);
        wr(12'h040, 32'hFFFF_FFFF);
        rd_chk(12'h040, 32'h0);
        `CHK(hresp, 1'b0)
        @(posedge clk); #1 `CHK(bus_reference_clock, 1'b0)
        @(posedge clk); wr(`OFS_CTRL, 32'h10);
        rd_chk(`OFS_CTRL, 32'h10);
        // clock enable low freezes the slave, so this write must be lost
        clk_en <= 1'b0; wr(`OFS_CTRL, 32'h1F); clk_en <= 1'b1;
        rd_chk(`OFS_CTRL, 32'h10);
        @(posedge clk); #1 `CHK(bus_reference_clock & clock_driver_en, 1'b1)
        @(posedge clk);
    endtask
    task automatic t_demux_write;
        wr(`OFS_TIMING0, tc(2, 2, 1, 1, 3, 1));
        wr(`OFS_ADDR, 32'h0000_1234); wr(`OFS_WDATA, 32'h0000_A55A);
        bus_cycle(32'h5, 4, 3, 1, 1'b0);
        `CHK(wd, 16'hA55A)
        `CHK(cs, 2'b10)
        `CHK(dedicated_addr_lines, 24'h00_1234)
        wr(`OFS_ADDR, 32'h0005_1234);
        bus_cycle(32'h5, 6, 3, 1, 1'b0);
    endtask
    task automatic t_zero_read;
        wr(`OFS_TIMING0, tc(1, 0, 0, 0, 1, 0)); rd_value <= 16'hC3E1;
        bus_cycle(32'h0, 1, 1, 0, 1'b0);
        rd_chk(`OFS_RDATA, 32'h0000_C3E1);
    endtask
    task automatic t_mux_read;
        wr(`OFS_CTRL, 32'h11); wr(`OFS_TIMING1, tc(1, 3, 0, 1, 2, 2));
        wr(`OFS_ADDR, 32'h0007_BEEF); rd_value <= 16'h5AA5;
        // window moves 05 to 07: one base unit plus three extra, then the turnaround unit
        bus_cycle(32'h2, 5, 2, 2, 1'b0);
        `CHK(lat, 16'hBEEF)
        `CHK(cs, 2'b01)
        rd_chk(`OFS_RDATA, 32'h0000_5AA5);
    endtask
    // ready costs at least the wait asked of the memory, exact latency is the design's
    task automatic t_ready;
        wr(`OFS_CTRL, 32'h16); ready_wait <= 4'h5; rd_value <= 16'h0F0F;
        bus_cycle(32'h0, 1, 5, 0, 1'b1);
        rd_chk(`OFS_RDATA, 32'h0000_0F0F);
        wr(`OFS_CTRL, 32'h1A); ready_pol <= 1'b0; ready_wait <= 4'h0;
        bus_cycle(32'h0, 1, 2, 0, 1'b1);
        ready_wait <= 4'h6;
        bus_cycle(32'h0, 1, 6, 0, 1'b1);
    endtask
    task finish_test;
        if (err_total == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            err_total++;
            finish_test;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_regs; t_demux_write; t_zero_read; t_mux_read; t_ready;
        finish_test;
    end
endmodule
`default_nettype wire
